// ===== logic/fsgw_consts.vh
`ifndef FSGW_CONSTS_VH
`define FSGW_CONSTS_VH
// scan list geometry
`define FSGW_LIST_MAX 320
`define FSGW_IDX_W 9
`define FSGW_ADDR_MAX 6'h3f
// command opcodes on the command port
`define FSGW_CMD_LIST 4'h0
`define FSGW_CMD_APPEND 4'h1
`define FSGW_CMD_INSERT 4'h2
`define FSGW_CMD_OVERWRITE 4'h3
`define FSGW_CMD_DELETE 4'h4
`define FSGW_CMD_VREAD 4'h5
`define FSGW_CMD_VWRITE 4'h6
`define FSGW_CMD_BREAD 4'h7
`define FSGW_CMD_CONFIG 4'h8
// reply error codes
`define FSGW_ERR_NONE 4'h0
`define FSGW_ERR_ARG 4'h1
`define FSGW_ERR_BUS 4'h2
`define FSGW_ERR_CMD 4'h3
// field bus bit rate and cycles per bit
`define FSGW_CLK_HZ 200000000
`define FSGW_FB_BPS 19200
`define FSGW_FB_BIT_CYC (`FSGW_CLK_HZ / `FSGW_FB_BPS)
// modbus function codes
`define FSGW_MB_RDREG 8'h03
`define FSGW_MB_WRREG 8'h06
`define FSGW_MB_DIAG 8'h08
`define FSGW_MB_WRMULT 8'h10
`define FSGW_MB_SLV_MAX 8'hf7
// data port config field positions
`define FSGW_CFG_MASTER 0
`define FSGW_CFG_ASCII 1
`define FSGW_CFG_PAR_LO 2
`define FSGW_CFG_PAR_HI 3
`define FSGW_CFG_STOP2 4
`define FSGW_CFG_RESET 8'h00
// master send interval default, cycles
`define FSGW_MASTER_IVL 32'd20000000
`endif

// ===== logic/fsgw_gateway.v
`timescale 1ns/1ps
`include "fsgw_consts.vh"
// Contract
// - scan list holds 320 address/vertical/horizontal entries
// - scan polls in order, wraps after last
// - buffer keeps value, status, events, comm status
// - list, append, insert, overwrite, delete commands
// - insert takes position, address, vertical, horizontal
// - direct read fetches and returns address, value
// - failed direct read returns error code
// - direct write returns address and stored value
// - buffer read returns fixed-width fields
// - field bus arbitrated between scan and config
// - scan, command, data ports run independently; scan starts no poll while a command shifts list entries
// - modbus functions 03, 06, 08, 16
// - slave address identifies one of 247
// - slave checks frame, decodes, then responds
// - master waits for response or timeout
// - master sends scan buffer at interval only
// - ascii and rtu modes selectable
// - data port settings set by command port
// - buffer reads return only requested registers
// - duplicate entries each polled in turn
// - field bus up to 64 addresses, 19.2k
// - 7N2/7E1/7O1 ascii, 8N1/8E1/8O1 rtu
module fsgw_gateway #(
    parameter LIST_MAX = `FSGW_LIST_MAX,
    parameter IW = `FSGW_IDX_W,
    parameter VAL_W = 32,
    parameter MASTER_IVL = `FSGW_MASTER_IVL,
    parameter MB_TIMEOUT = 32'd2000000
) (
    input wire clk,
    input wire sys_rst,
    // command port
    input wire cmd_valid,
    output wire cmd_ready,
    input wire [3:0] cmd_op,
    input wire [IW-1:0] cmd_pos,
    input wire [5:0] cmd_addr,
    input wire [3:0] cmd_vert,
    input wire [3:0] cmd_horz,
    input wire [VAL_W-1:0] cmd_value,
    input wire [7:0] cmd_cfg,
    output reg rsp_valid,
    output reg [3:0] rsp_err,
    output reg [IW-1:0] rsp_pos,
    output reg [5:0] rsp_addr,
    output reg [VAL_W-1:0] rsp_value,
    output reg [7:0] rsp_event,
    output reg [7:0] rsp_status,
    output reg [IW-1:0] list_len_r,
    // field bus transaction port
    output reg fb_req,
    output reg fb_write,
    output reg [5:0] fb_addr,
    output reg [3:0] fb_vert,
    output reg [3:0] fb_horz,
    output reg [VAL_W-1:0] fb_wdata,
    input wire fb_done,
    input wire fb_fail,
    input wire [VAL_W-1:0] fb_rdata,
    input wire [7:0] fb_mstat,
    input wire [7:0] fb_event,
    // data port frames from the framer
    output reg [7:0] mb_cfg_r,
    input wire mb_frame_valid,
    input wire mb_frame_crc_ok,
    input wire [7:0] mb_slave,
    input wire [7:0] mb_func,
    input wire [15:0] mb_start,
    input wire [15:0] mb_count,
    input wire [7:0] mb_own_addr,
    output reg mb_tx_valid,
    output reg [7:0] mb_tx_func,
    output reg [15:0] mb_tx_reg,
    output reg [15:0] mb_tx_data,
    output reg mb_tx_exc,
    input wire mb_tx_done
);
    ////////////////////////////////////////////////////////////////////
    // scan list and buffer storage
    reg [13:0] list_mem [0:LIST_MAX-1]; // addr,vert,horz
    reg [VAL_W-1:0] buf_val [0:LIST_MAX-1]; // measured value
    reg [23:0] buf_stat [0:LIST_MAX-1]; // mstat, event, comm
    localparam [IW-1:0] MAXI = LIST_MAX;
    localparam [IW-1:0] ONE = 1;

    ////////////////////////////////////////////////////////////////////
    // command engine states, one-hot
    localparam [4:0] C_IDLE = 5'h01;
    localparam [4:0] C_SHIFT = 5'h02;
    localparam [4:0] C_BUS = 5'h04;
    localparam [4:0] C_WAIT = 5'h08;
    localparam [4:0] C_DONE = 5'h10;
    reg [4:0] cst_r;
    reg [3:0] op_r; // latched opcode
    reg [IW-1:0] mv_r; // walker for shifting entries
    reg [IW-1:0] tgt_r; // target index
    reg [13:0] ent_r; // entry being placed
    reg cfg_bus_r; // config path wants the field bus
    reg cfg_bus_wr_r;
    reg [VAL_W-1:0] cfg_wval_r;

    // scan engine
    reg [IW-1:0] scan_idx_r;
    reg scan_busy_r; // scan owns the field bus
    reg cfg_owns_r; // config owns the field bus

    assign cmd_ready = (cst_r == C_IDLE);

    // failed checks leave the list untouched
    wire arg_addr_ok = (cmd_addr <= `FSGW_ADDR_MAX);
    wire ins_ok = (cmd_pos <= list_len_r) && (list_len_r < MAXI);
    wire idx_ok = (cmd_pos < list_len_r);

    ////////////////////////////////////////////////////////////////////
    // command interpreter
    always @(posedge clk) begin
        if (sys_rst) begin
            cst_r <= C_IDLE;
            op_r <= 4'h0;
            mv_r <= {IW{1'b0}};
            tgt_r <= {IW{1'b0}};
            ent_r <= 14'h0000;
            list_len_r <= {IW{1'b0}};
            cfg_bus_r <= 1'b0;
            cfg_bus_wr_r <= 1'b0;
            cfg_wval_r <= {VAL_W{1'b0}};
            rsp_valid <= 1'b0;
            rsp_err <= `FSGW_ERR_NONE;
            rsp_pos <= {IW{1'b0}};
            rsp_addr <= 6'h00;
            rsp_value <= {VAL_W{1'b0}};
            rsp_event <= 8'h00;
            rsp_status <= 8'h00;
            mb_cfg_r <= `FSGW_CFG_RESET;
        end else begin
            rsp_valid <= 1'b0;
            // scan results land here: one buffer writer
            if (scan_busy_r && fb_done && cst_r != C_SHIFT
                    && scan_idx_r < list_len_r) begin
                if (!fb_fail)
                    buf_val[scan_idx_r] <= fb_rdata;
                buf_stat[scan_idx_r] <= {fb_mstat, fb_event, 7'h00, fb_fail};
            end
            case (cst_r)
                C_IDLE: begin
                    if (cmd_valid) begin
                        op_r <= cmd_op;
                        tgt_r <= cmd_pos;
                        ent_r <= {cmd_addr, cmd_vert, cmd_horz};
                        rsp_err <= `FSGW_ERR_NONE;
                        rsp_pos <= cmd_pos;
                        rsp_addr <= cmd_addr;
                        cst_r <= C_DONE;
                        case (cmd_op)
                            `FSGW_CMD_LIST,
                            `FSGW_CMD_BREAD: begin
                                if (idx_ok) begin
                                    // one index, one cycle: coherent
                                    rsp_addr <= list_mem[cmd_pos][13:8];
                                    rsp_value <= buf_val[cmd_pos];
                                    rsp_event <= buf_stat[cmd_pos][15:8];
                                    rsp_status <= buf_stat[cmd_pos][7:0];
                                end else begin
                                    rsp_err <= `FSGW_ERR_ARG;
                                end
                            end
                            `FSGW_CMD_APPEND: begin
                                if (list_len_r < MAXI && arg_addr_ok) begin
                                    tgt_r <= list_len_r;
                                    rsp_pos <= list_len_r;
                                    mv_r <= list_len_r;
                                    cst_r <= C_SHIFT;
                                end else begin
                                    rsp_err <= `FSGW_ERR_ARG;
                                end
                            end
                            `FSGW_CMD_INSERT: begin
                                if (ins_ok && arg_addr_ok) begin
                                    mv_r <= list_len_r;
                                    cst_r <= C_SHIFT;
                                end else begin
                                    rsp_err <= `FSGW_ERR_ARG;
                                end
                            end
                            `FSGW_CMD_OVERWRITE: begin
                                if (idx_ok && arg_addr_ok) begin
                                    mv_r <= cmd_pos;
                                    cst_r <= C_SHIFT;
                                end else begin
                                    rsp_err <= `FSGW_ERR_ARG;
                                end
                            end
                            `FSGW_CMD_DELETE: begin
                                if (idx_ok) begin
                                    mv_r <= cmd_pos;
                                    cst_r <= C_SHIFT;
                                end else begin
                                    rsp_err <= `FSGW_ERR_ARG;
                                end
                            end
                            `FSGW_CMD_VREAD,
                            `FSGW_CMD_VWRITE: begin
                                if (arg_addr_ok) begin
                                    cfg_bus_r <= 1'b1;
                                    cfg_bus_wr_r <= (cmd_op == `FSGW_CMD_VWRITE);
                                    cfg_wval_r <= cmd_value;
                                    cst_r <= C_BUS;
                                end else begin
                                    rsp_err <= `FSGW_ERR_ARG;
                                end
                            end
                            `FSGW_CMD_CONFIG: begin
                                mb_cfg_r <= cmd_cfg;
                            end
                            default: begin
                                rsp_err <= `FSGW_ERR_CMD;
                            end
                        endcase
                    end
                end
                C_SHIFT: begin
                    // one entry moves per cycle; scan starts no poll and drops results meanwhile
                    if (op_r == `FSGW_CMD_DELETE) begin
                        if (mv_r + ONE < list_len_r) begin
                            list_mem[mv_r] <= list_mem[mv_r + ONE];
                            buf_val[mv_r] <= buf_val[mv_r + ONE];
                            buf_stat[mv_r] <= buf_stat[mv_r + ONE];
                            mv_r <= mv_r + ONE;
                        end else begin
                            list_len_r <= list_len_r - ONE;
                            cst_r <= C_DONE;
                        end
                    end else if (mv_r > tgt_r) begin
                        list_mem[mv_r] <= list_mem[mv_r - ONE];
                        buf_val[mv_r] <= buf_val[mv_r - ONE];
                        buf_stat[mv_r] <= buf_stat[mv_r - ONE];
                        mv_r <= mv_r - ONE;
                    end else begin
                        list_mem[tgt_r] <= ent_r;
                        buf_stat[tgt_r] <= 24'h0;
                        if (op_r != `FSGW_CMD_OVERWRITE)
                            list_len_r <= list_len_r + ONE;
                        cst_r <= C_DONE;
                    end
                end
                C_BUS: begin
                    if (cfg_owns_r)
                        cst_r <= C_WAIT;
                end
                C_WAIT: begin
                    if (fb_done) begin
                        cfg_bus_r <= 1'b0;
                        if (fb_fail)
                            rsp_err <= `FSGW_ERR_BUS;
                        else
                            rsp_value <= fb_rdata;
                        cst_r <= C_DONE;
                    end
                end
                C_DONE: begin
                    rsp_valid <= 1'b1;
                    cst_r <= C_IDLE;
                end
                default: cst_r <= C_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // field bus arbiter and scan; config wins between polls
    always @(posedge clk) begin
        if (sys_rst) begin
            scan_idx_r <= {IW{1'b0}};
            scan_busy_r <= 1'b0;
            cfg_owns_r <= 1'b0;
            fb_req <= 1'b0;
            fb_write <= 1'b0;
            fb_addr <= 6'h00;
            fb_vert <= 4'h0;
            fb_horz <= 4'h0;
            fb_wdata <= {VAL_W{1'b0}};
        end else begin
            fb_req <= 1'b0;
            if (scan_busy_r) begin
                if (fb_done) begin
                    scan_busy_r <= 1'b0;
                    // next entry, duplicates polled as listed
                    if (scan_idx_r + ONE >= list_len_r)
                        scan_idx_r <= {IW{1'b0}};
                    else
                        scan_idx_r <= scan_idx_r + ONE;
                end
            end else if (cfg_owns_r) begin
                if (fb_done)
                    cfg_owns_r <= 1'b0;
            end else if (cfg_bus_r && cst_r == C_BUS) begin
                cfg_owns_r <= 1'b1;
                fb_req <= 1'b1;
                fb_write <= cfg_bus_wr_r;
                fb_addr <= ent_r[13:8];
                fb_vert <= ent_r[7:4];
                fb_horz <= ent_r[3:0];
                fb_wdata <= cfg_wval_r;
            end else if (list_len_r != {IW{1'b0}} && cst_r != C_SHIFT) begin
                if (scan_idx_r >= list_len_r) begin
                    scan_idx_r <= {IW{1'b0}};
                end else begin
                    scan_busy_r <= 1'b1;
                    fb_req <= 1'b1;
                    fb_write <= 1'b0;
                    fb_addr <= list_mem[scan_idx_r][13:8];
                    fb_vert <= list_mem[scan_idx_r][7:4];
                    fb_horz <= list_mem[scan_idx_r][3:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data port: slave answers, master pushes
    localparam [2:0] M_IDLE = 3'h1;
    localparam [2:0] M_SEND = 3'h2;
    localparam [2:0] M_WAIT = 3'h4;
    reg [2:0] mst_r;
    reg [31:0] tmr_r; // interval or reply timeout
    reg [IW-1:0] mb_idx_r;
    wire is_master = mb_cfg_r[`FSGW_CFG_MASTER];
    wire func_ok = (mb_func == `FSGW_MB_RDREG) || (mb_func == `FSGW_MB_WRREG)
        || (mb_func == `FSGW_MB_DIAG) || (mb_func == `FSGW_MB_WRMULT);
    wire [IW-1:0] rq_idx = mb_start[IW-1:0];

    always @(posedge clk) begin
        if (sys_rst) begin
            mst_r <= M_IDLE;
            tmr_r <= 32'h00000000;
            mb_idx_r <= {IW{1'b0}};
            mb_tx_valid <= 1'b0;
            mb_tx_func <= 8'h00;
            mb_tx_reg <= 16'h0;
            mb_tx_data <= 16'h0;
            mb_tx_exc <= 1'b0;
        end else begin
            case (mst_r)
                M_IDLE: begin
                    mb_tx_valid <= 1'b0;
                    if (is_master) begin
                        // push each interval
                        if (tmr_r >= MASTER_IVL && list_len_r != 0) begin
                            tmr_r <= 32'h00000000;
                            mb_tx_valid <= 1'b1;
                            mb_tx_func <= `FSGW_MB_WRMULT;
                            mb_tx_reg <= {{(16-IW){1'b0}}, mb_idx_r};
                            mb_tx_data <= buf_val[mb_idx_r][15:0];
                            mb_tx_exc <= 1'b0;
                            mst_r <= M_WAIT;
                        end else begin
                            tmr_r <= tmr_r + 32'h00000001;
                        end
                    end else if (mb_frame_valid && mb_frame_crc_ok
                            && mb_slave == mb_own_addr
                            && mb_own_addr != 8'h00
                            && mb_own_addr <= `FSGW_MB_SLV_MAX) begin
                        mb_tx_valid <= 1'b1;
                        mb_tx_func <= mb_func;
                        mb_tx_reg <= mb_start;
                        mb_tx_exc <= !func_ok || (rq_idx >= list_len_r
                            && mb_func != `FSGW_MB_DIAG);
                        // addressed register only
                        mb_tx_data <= (mb_func == `FSGW_MB_DIAG) ?
                            mb_count : buf_val[rq_idx][15:0];
                        mst_r <= M_SEND;
                    end
                end
                M_SEND: begin
                    if (mb_tx_done) begin
                        mb_tx_valid <= 1'b0;
                        mst_r <= M_IDLE;
                    end
                end
                M_WAIT: begin
                    // reply or timeout
                    if (mb_tx_done)
                        mb_tx_valid <= 1'b0;
                    if ((mb_frame_valid && mb_frame_crc_ok)
                            || tmr_r >= MB_TIMEOUT) begin
                        mb_tx_valid <= 1'b0;
                        tmr_r <= 32'h00000000;
                        if (mb_idx_r + ONE >= list_len_r)
                            mb_idx_r <= {IW{1'b0}};
                        else
                            mb_idx_r <= mb_idx_r + ONE;
                        mst_r <= M_IDLE;
                    end else begin
                        tmr_r <= tmr_r + 32'h00000001;
                    end
                end
                default: mst_r <= M_IDLE;
            endcase
        end
    end
    // framer takes char format from mb_cfg_r
endmodule // fsgw_gateway

// ===== tb/fsgw_gateway_monitor.sv
`timescale 1ns/1ps
`include "fsgw_consts.vh"
// port-level checker for the gateway
module fsgw_chk #(
    parameter IW = 9,
    parameter LIST_MAX = 320
) (
    input wire clk,
    input wire sys_rst,
    input wire cmd_valid,
    input wire cmd_ready,
    input wire [3:0] cmd_op,
    input wire [7:0] cmd_cfg,
    input wire rsp_valid,
    input wire [3:0] rsp_err,
    input wire [IW-1:0] list_len_r,
    input wire fb_req,
    input wire fb_done,
    input wire [7:0] mb_cfg_r,
    input wire mb_frame_valid,
    input wire mb_frame_crc_ok,
    input wire [7:0] mb_slave,
    input wire [7:0] mb_own_addr,
    input wire mb_tx_valid,
    input wire [7:0] mb_tx_func,
    input wire [15:0] mb_tx_data,
    input wire mb_tx_exc,
    input wire mb_tx_done
);
////////////////////////////////////////////////////////////
// one field bus transaction at a time
reg pend_r;
always @(posedge clk) begin
    if (sys_rst)
        pend_r <= 1'b0;
    else if (fb_req)
        pend_r <= 1'b1;
    else if (fb_done)
        pend_r <= 1'b0;
end
////////////////////////////////////////////////////////////
default clocking cb @(posedge clk); endclocking
default disable iff (sys_rst);
sequence s_cfg_take;
    cmd_valid && cmd_ready && cmd_op == `FSGW_CMD_CONFIG;
endsequence
sequence s_own_frame;
    mb_frame_valid && mb_frame_crc_ok && mb_slave == mb_own_addr &&
    mb_own_addr != 8'h00 && mb_own_addr <= `FSGW_MB_SLV_MAX;
endsequence
property p_rsp_pulse;
    rsp_valid |=> !rsp_valid;
endproperty
property p_fb_single;
    fb_req |-> !pend_r;
endproperty
property p_len_max;
    list_len_r <= LIST_MAX;
endproperty
// one edit moves length by one
property p_len_step;
    !$past(sys_rst) && !$stable(list_len_r) |->
        list_len_r == $past(list_len_r) + 1'b1 ||
        list_len_r == $past(list_len_r) - 1'b1;
endproperty
property p_arg_keep;
    rsp_valid && rsp_err == `FSGW_ERR_ARG |->
        list_len_r == $past(list_len_r, 3);
endproperty
property p_cfg;
    s_cfg_take |-> ##2 (rsp_valid && mb_cfg_r == $past(cmd_cfg, 2));
endproperty
property p_slave_ans;
    (!mb_cfg_r[0] && !mb_tx_valid) ##0 s_own_frame |=> mb_tx_valid;
endproperty
property p_crc_drop;
    !mb_cfg_r[0] && !mb_tx_valid && mb_frame_valid && !mb_frame_crc_ok
        |=> !mb_tx_valid;
endproperty
property p_slave_func;
    mb_tx_valid && !mb_tx_exc |-> mb_tx_func inside {`FSGW_MB_RDREG,
        `FSGW_MB_WRREG, `FSGW_MB_DIAG, `FSGW_MB_WRMULT};
endproperty
property p_master_func;
    mb_tx_valid && mb_cfg_r[0] |->
        mb_tx_func == `FSGW_MB_WRMULT && !mb_tx_exc;
endproperty
// slave reply held until taken
property p_tx_hold;
    !mb_cfg_r[0] && mb_tx_valid && !mb_tx_done |=>
        mb_tx_valid && $stable(mb_tx_data);
endproperty
a_rsp_pulse: assert property (p_rsp_pulse)
    else $error("reply strobe longer than one cycle");
a_fb_single: assert property (p_fb_single)
    else $error("field bus request while one is pending");
a_len_max: assert property (p_len_max)
    else $error("list length above maximum");
a_len_step: assert property (p_len_step)
    else $error("list length jumped");
a_arg_keep: assert property (p_arg_keep)
    else $error("refused command changed list length");
a_cfg: assert property (p_cfg)
    else $error("data port setting not applied");
a_slave_ans: assert property (p_slave_ans)
    else $error("addressed frame not answered");
a_crc_drop: assert property (p_crc_drop)
    else $error("corrupt frame answered");
a_slave_func: assert property (p_slave_func)
    else $error("unsupported function code answered");
a_master_func: assert property (p_master_func)
    else $error("master sent other than buffer write");
a_tx_hold: assert property (p_tx_hold)
    else $error("slave reply dropped or changed");
endmodule // fsgw_chk
bind fsgw_gateway fsgw_chk #(.IW(IW), .LIST_MAX(LIST_MAX)) u_fsgw_chk (.*);

// ===== tb/fsgw_fb_model.sv
`timescale 1ns/1ps
// field bus transmitters behind the gateway
module fsgw_fb_model (
    input wire clk,
    input wire sys_rst,
    input wire fb_req,
    input wire fb_write,
    input wire [5:0] fb_addr,
    input wire [3:0] fb_vert,
    input wire [31:0] fb_wdata,
    input wire [7:0] lat,
    input wire [5:0] dead_addr,
    output reg fb_done,
    output reg fb_fail,
    output reg [31:0] fb_rdata,
    output reg [7:0] fb_mstat,
    output reg [7:0] fb_event
);
reg [31:0] mem_r [0:63]; // one value per bus address
reg busy_r;
reg [7:0] cnt_r; // cycles to reply
integer i;
initial for (i = 0; i < 64; i = i + 1) mem_r[i] = 32'h1000 + i;
////////////////////////////////////////////////////////////
// reply lat+1 cycles after the request; data toggles between replies
always @(posedge clk) begin
    fb_done <= 1'b0;
    fb_rdata <= ~fb_rdata;
    fb_mstat <= ~fb_mstat;
    fb_event <= ~fb_event;
    fb_fail <= ~fb_fail;
    if (sys_rst) begin
        busy_r <= 1'b0;
        fb_rdata <= 32'h0;
        fb_mstat <= 8'h00;
        fb_event <= 8'h00;
        fb_fail <= 1'b0;
    end else if (fb_req) begin
        busy_r <= 1'b1;
        cnt_r <= lat;
    end else if (busy_r && cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
    end else if (busy_r) begin
        // dead address fails
        busy_r <= 1'b0;
        fb_done <= 1'b1;
        fb_fail <= (fb_addr == dead_addr);
        fb_rdata <= fb_write ? fb_wdata : mem_r[fb_addr];
        fb_mstat <= {2'b00, fb_addr};
        fb_event <= {4'h0, fb_vert};
        if (fb_write)
            mem_r[fb_addr] <= fb_wdata;
    end
end
endmodule // fsgw_fb_model

// ===== tb/fsgw_gateway_test.sv
`timescale 1ns/1ps
`include "fsgw_consts.vh"
module fsgw_gateway_test;
reg clk = 0, sys_rst = 1, cmd_valid = 0, mb_frame_valid = 0;
reg mb_frame_crc_ok = 0, mb_tx_done = 0;
reg [3:0] cmd_op = 0, cmd_vert = 0, cmd_horz = 0;
reg [8:0] cmd_pos = 0;
reg [5:0] cmd_addr = 0, dead_addr = 6'h3e;
reg [31:0] cmd_value = 0;
reg [7:0] cmd_cfg = 0, mb_slave = 0, mb_func = 0, lat = 2;
reg [7:0] mb_own_addr = 8'h11;
reg [15:0] mb_start = 0, mb_count = 0;
wire cmd_ready, rsp_valid, fb_req, fb_write, fb_done, fb_fail;
wire mb_tx_valid, mb_tx_exc;
wire [3:0] rsp_err, fb_vert, fb_horz;
wire [8:0] rsp_pos, list_len_r;
wire [5:0] rsp_addr, fb_addr;
wire [31:0] rsp_value, fb_wdata, fb_rdata;
wire [7:0] rsp_event, rsp_status, fb_mstat, fb_event, mb_cfg_r, mb_tx_func;
wire [15:0] mb_tx_reg, mb_tx_data;
integer mismatches = 0, checks_done = 0, i;
// expected list after the edits, entry 0 lowest
localparam [23:0] EA = {6'd9, 6'd12, 6'd6, 6'd9};
localparam [47:0] CFGS = {8'h00, 8'h08, 8'h04, 8'h0a, 8'h06, 8'h12};
localparam [47:0] MF = {8'h03, 8'h2b, 8'h10, 8'h08, 8'h06, 8'h03};
localparam [15:0] BAD = {4'h7, 4'h4, 4'h3, 4'h2};
always #2.5 clk = ~clk;
// short intervals for a brief test
fsgw_gateway #(.MASTER_IVL(100), .MB_TIMEOUT(50)) u_fsgw_gateway (.*);
fsgw_fb_model u_fsgw_fb_model (.*);
////////////////////////////////////////////////////////////
task chk(input [8*6:1] nm, input [31:0] e, input [31:0] g);
begin
    checks_done = checks_done + 1;
    if (g !== e) begin
        mismatches = mismatches + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
    end
end
endtask
// one command, then its reply strobe
task cmd(input [3:0] op, input [8:0] p, input [5:0] a, input [3:0] v,
    input [31:0] val);
integer n;
begin
    n = 0;
    while (cmd_ready !== 1'b1 && n < 3000) @(posedge clk) #1 n = n + 1;
    {cmd_op, cmd_pos, cmd_addr, cmd_vert, cmd_value} = {op, p, a, v, val};
    cmd_horz = v ^ 4'h1;
    cmd_valid = 1;
    @(posedge clk) #1 cmd_valid = 0;
    while (rsp_valid !== 1'b1 && n < 3000) @(posedge clk) #1 n = n + 1;
    if (n >= 3000)
        chk("rspto", 1, 0);
end
endtask
task wtx(input v, input integer lim);
integer n;
begin
    n = 0;
    while (mb_tx_valid !== v && n < lim) @(posedge clk) #1 n = n + 1;
end
endtask
// one decoded frame
task mbf(input [7:0] s, input [7:0] f, input [15:0] st, input ok);
begin
    {mb_slave, mb_func, mb_start, mb_count} = {s, f, st, 16'h0001};
    mb_frame_crc_ok = ok;
    mb_frame_valid = 1;
    @(posedge clk) #1 mb_frame_valid = 0;
    wtx(1, 20);
end
endtask
task results;
begin
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
end
endtask
////////////////////////////////////////////////////////////
initial begin
    #100000;
    mismatches = mismatches + 1;
    $display("watchdog expired");
    results;
end
initial begin
    repeat (6) @(posedge clk);
    #1 sys_rst = 0;
    chk("len", 0, list_len_r);
    for (i = 0; i < 3; i = i + 1) cmd(`FSGW_CMD_APPEND, 0, 5 + i, 3, 0);
    cmd(`FSGW_CMD_INSERT, 1, 9, 3, 0);
    chk("len", 4, list_len_r);
    cmd(`FSGW_CMD_OVERWRITE, 3, 12, 3, 0);
    cmd(`FSGW_CMD_DELETE, 0, 0, 0, 0);
    chk("len", 3, list_len_r);
    cmd(`FSGW_CMD_APPEND, 0, 9, 3, 0);
    cmd(`FSGW_CMD_LIST, 0, 0, 0, 0);
    $display("list edit test done");
    for (i = 0; i < 4; i = i + 1) begin
        cmd(BAD[i*4+:4], (i == 0) ? 5 : 4, 1, 0, 0);
        chk("err", `FSGW_ERR_ARG, rsp_err);
    end
    cmd(4'hf, 0, 0, 0, 0);
    chk("err", `FSGW_ERR_CMD, rsp_err);
    chk("len", 4, list_len_r);
    $display("refusal test done");
    repeat (400) @(posedge clk);
    for (i = 0; i < 4; i = i + 1) begin
        cmd(`FSGW_CMD_BREAD, i, 0, 0, 0);
        chk("addr", EA[i*6+:6], rsp_addr);
        chk("pos", i, rsp_pos);
        chk("val", 32'h1000 + EA[i*6+:6], rsp_value);
        chk("evt", 8'h03, rsp_event);
    end
    $display("scan buffer test done");
    lat = 40;
    cmd(`FSGW_CMD_VREAD, 0, 20, 1, 0);
    chk("addr", 20, rsp_addr);
    chk("val", 32'h1014, rsp_value);
    cmd(`FSGW_CMD_VREAD, 0, 6'h3e, 1, 0);
    chk("err", `FSGW_ERR_BUS, rsp_err);
    cmd(`FSGW_CMD_VWRITE, 0, 20, 1, 32'h55);
    chk("val", 32'h55, rsp_value);
    cmd(`FSGW_CMD_VREAD, 0, 20, 1, 0);
    chk("val", 32'h55, rsp_value);
    lat = 2;
    $display("direct access test done");
    for (i = 0; i < 6; i = i + 1) begin
        cmd_cfg = CFGS[i*8+:8];
        cmd(`FSGW_CMD_CONFIG, 0, 0, 0, 0);
        chk("cfg", CFGS[i*8+:8], mb_cfg_r);
    end
    for (i = 0; i < 6; i = i + 1) begin
        mbf(8'h11, MF[i*8+:8], (i == 5) ? 4 : 0, 1);
        chk("tx", 1, mb_tx_valid);
        chk("exc", i >= 4, mb_tx_exc);
        if (i == 2) chk("diag", 1, mb_tx_data);
        mb_tx_done = 1;
        @(posedge clk) #1 mb_tx_done = 0;
        @(posedge clk) #1;
    end
    mbf(8'h12, 8'h03, 0, 1);
    chk("tx", 0, mb_tx_valid);
    mbf(8'h11, 8'h03, 0, 0);
    chk("tx", 0, mb_tx_valid);
    $display("slave test done");
    cmd_cfg = 8'h01;
    cmd(`FSGW_CMD_CONFIG, 0, 0, 0, 0);
    wtx(1, 300);
    chk("reg", 0, mb_tx_reg);
    chk("data", 16'h1009, mb_tx_data);
    wtx(0, 100);
    wtx(1, 300);
    chk("reg", 1, mb_tx_reg);
    chk("data", 16'h1006, mb_tx_data);
    wtx(0, 100);
    $display("master test done");
    results;
end
endmodule // fsgw_gateway_test
